// file: rtl/dlac_regs.v
// dlac_regs: control register slice for audio clock dividers, link
// error counting, control channel mode with reverse spi, and equalizer.
// assumes a control bus slave in front presents byte-wide register
// accesses on sys_clk, and that spi pins arrive asynchronously.
`include "dlac_consts.vh"
module dlac_regs
(
   input  wire       sys_clk,
   input  wire       sys_rst,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata_q,
   output reg        reg_rvalid_q,
   input  wire [2:0] pll_state_machine_out_sel,
   input  wire [1:0] pll_state_machine_in_sel,
   output reg  [2:0] mclk_div_log2_q,
   output reg  [1:0] vco_in_div_log2_q,
   input  wire       link_acquired,
   input  wire       err_clk0,
   input  wire       err_clk1,
   input  wire       link_data_channel_err,
   output wire       link_lock,
   output wire       lock_drop,
   input  wire [5:0] adapt_eq_value,
   output reg  [5:0] eq_setting_q,
   output reg        eq_adapt_en_q,
   output reg        cc_gpio_normal_q,
   output reg  [2:0] cc_hs_gpio_count_q,
   output reg        cc_fwd_spi_q,
   output reg        cc_hs_fwd_spi_q,
   output reg        cc_hs_rev_spi_q,
   input  wire       spi_sclk,
   input  wire       spi_ss_n,
   input  wire       spi_mosi,
   output reg        spi_miso_o_q,
   output wire       spi_miso_oe,
   input  wire [7:0] rev_tx_data,
   output reg  [7:0] rev_rx_data_q,
   output reg        rev_rx_valid_q
);
   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   reg  [7:0] audio_clock_divider_select_q;
   reg  [7:0] link_fault_count_ctl_q;
   reg  [7:0] control_channel_speed_ctl_q;
   reg  [7:0] equalizer_manual_setting_q;
   wire       audio_out_divider_override =
              audio_clock_divider_select_q[`DLAC_AD_OUT_OVR];
   wire [2:0] vco_output_divide_select =
              audio_clock_divider_select_q[`DLAC_AD_OUT_SEL_HI:
                                           `DLAC_AD_OUT_SEL_LO];
   wire       vco_input_divide_override =
              audio_clock_divider_select_q[`DLAC_AD_IN_OVR];
   wire [1:0] vco_input_divide_select =
              audio_clock_divider_select_q[`DLAC_AD_IN_SEL_HI:
                                           `DLAC_AD_IN_SEL_LO];
   wire       count_en  = link_fault_count_ctl_q[`DLAC_LF_CNT_EN];
   wire [3:0] threshold =
              link_fault_count_ctl_q[`DLAC_LF_THR_HI:`DLAC_LF_THR_LO];
   wire       miso_mode = control_channel_speed_ctl_q[`DLAC_CC_MISO_MODE];
   wire       serial_clock_polarity =
              control_channel_speed_ctl_q[`DLAC_CC_CPOL];
   wire [2:0] control_channel_speed_mode =
              control_channel_speed_ctl_q[`DLAC_CC_MODE_HI:
                                          `DLAC_CC_MODE_LO];
   wire [2:0] equalizer_upper_manual =
              equalizer_manual_setting_q[`DLAC_EQ_UPPER_HI:
                                         `DLAC_EQ_UPPER_LO];
   wire [2:0] equalizer_lower_manual =
              equalizer_manual_setting_q[`DLAC_EQ_LOWER_HI:
                                         `DLAC_EQ_LOWER_LO];
   wire       equalizer_adapt_disable =
              equalizer_manual_setting_q[`DLAC_EQ_BYPASS];
   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // reserved read/write bits are stored so software sees what it wrote
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         audio_clock_divider_select_q <= `DLAC_RST_AUDIO_DIV;
         link_fault_count_ctl_q       <= `DLAC_RST_LINK_FAULT;
         control_channel_speed_ctl_q  <= `DLAC_RST_CC_SPEED;
         equalizer_manual_setting_q   <= `DLAC_RST_EQ_MANUAL;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `DLAC_ADDR_AUDIO_DIV:
            begin
               audio_clock_divider_select_q <= reg_wdata;
               // read-only reserved bit never takes a write
               audio_clock_divider_select_q[`DLAC_AD_RSVD_RO] <= 1'b0;
            end
            `DLAC_ADDR_LINK_FAULT: link_fault_count_ctl_q      <= reg_wdata;
            `DLAC_ADDR_CC_SPEED:   control_channel_speed_ctl_q <= reg_wdata;
            `DLAC_ADDR_EQ_MANUAL:  equalizer_manual_setting_q  <= reg_wdata;
            default: ; // status and unmapped offsets ignore writes
         endcase
      end
   end
   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   // read data is registered: answer one cycle after the strobe
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         reg_rdata_q  <= 8'h00;
         reg_rvalid_q <= 1'b0;
      end
      else
      begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd)
            case (reg_addr)
               `DLAC_ADDR_AUDIO_DIV:
                  reg_rdata_q <= audio_clock_divider_select_q;
               `DLAC_ADDR_EQUALIZER_SETTING_READBACK:
                  reg_rdata_q <= {2'h0, eq_setting_q};
               `DLAC_ADDR_LINK_FAULT: reg_rdata_q <= link_fault_count_ctl_q;
               `DLAC_ADDR_CC_SPEED:
                  reg_rdata_q <= control_channel_speed_ctl_q;
               `DLAC_ADDR_EQ_MANUAL:
                  reg_rdata_q <= equalizer_manual_setting_q;
               default:               reg_rdata_q <= `DLAC_RD_UNMAPPED;
            endcase
      end
   end
   // ----------------------------------------------------------------
   // audio clock divider chain
   // ----------------------------------------------------------------
   wire [2:0] out_sel = audio_out_divider_override ?
                        vco_output_divide_select :
                        pll_state_machine_out_sel;
   wire [1:0] in_sel  = vco_input_divide_override ?
                        vco_input_divide_select :
                        pll_state_machine_in_sel;
   reg  [2:0] out_log2_d;
   // outputs are log2 of the divide ratio: 5 means divide by 32
   always @*
   begin
      case (out_sel)
         3'h0:    out_log2_d = 3'h5;
         3'h1:    out_log2_d = 3'h4;
         3'h2:    out_log2_d = 3'h3;
         3'h3:    out_log2_d = 3'h2;
         3'h4, 3'h5: out_log2_d = 3'h1;
         default: out_log2_d = 3'h0;
      endcase
   end
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         mclk_div_log2_q   <= 3'h5;
         vco_in_div_log2_q <= 2'h0;
      end
      else
      begin
         mclk_div_log2_q   <= out_log2_d;
         vco_in_div_log2_q <= in_sel;           // code n divides by 2^n
      end
   end
   // ----------------------------------------------------------------
   // equalizer setting
   // ----------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         eq_setting_q  <= 6'h00;
         eq_adapt_en_q <= 1'b0;
      end
      else
      begin
         eq_adapt_en_q <= ~equalizer_adapt_disable;
         if (equalizer_adapt_disable)
            eq_setting_q <= {equalizer_upper_manual,
                             equalizer_lower_manual};
         else
            eq_setting_q <= adapt_eq_value;
      end
   end
   // ----------------------------------------------------------------
   // link error monitor
   // ----------------------------------------------------------------
   dlac_link_monitor u_mon
   (
      .sys_clk               (sys_clk),
      .sys_rst               (sys_rst),
      .link_acquired         (link_acquired),
      .err_clk0              (err_clk0),
      .err_clk1              (err_clk1),
      .link_data_channel_err (link_data_channel_err),
      .count_en              (count_en),
      .threshold             (threshold),
      .link_lock_q           (link_lock),
      .err_count_q           (),
      .lock_drop_q           (lock_drop)
   );
   // ----------------------------------------------------------------
   // control channel mode decode
   // ----------------------------------------------------------------
   // code 110 is undefined and leaves every mode flag low
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         cc_gpio_normal_q   <= 1'b1;
         cc_hs_gpio_count_q <= 3'h0;
         cc_fwd_spi_q       <= 1'b0;
         cc_hs_fwd_spi_q    <= 1'b0;
         cc_hs_rev_spi_q    <= 1'b0;
      end
      else
      begin
         cc_gpio_normal_q <= (control_channel_speed_mode == `DLAC_CCM_GPIO);
         case (control_channel_speed_mode)
            `DLAC_CCM_HS_GPIO1: cc_hs_gpio_count_q <= 3'h1;
            `DLAC_CCM_HS_GPIO2: cc_hs_gpio_count_q <= 3'h2;
            `DLAC_CCM_HS_GPIO4: cc_hs_gpio_count_q <= 3'h4;
            default:            cc_hs_gpio_count_q <= 3'h0;
         endcase
         cc_fwd_spi_q    <= (control_channel_speed_mode == `DLAC_CCM_FWD_SPI);
         cc_hs_fwd_spi_q <=
            (control_channel_speed_mode == `DLAC_CCM_HS_FWD_SPI);
         cc_hs_rev_spi_q <=
            (control_channel_speed_mode == `DLAC_CCM_HS_REV_SPI);
      end
   end
   // ----------------------------------------------------------------
   // reverse spi slave pins
   // ----------------------------------------------------------------
   reg  [2:0] sync1_q;
   reg  [2:0] sync2_q;
   reg        sclk_prev_q;
   reg        ss_n_prev_q;
   reg  [7:0] rx_sh_q;
   reg  [7:0] tx_sh_q;
   reg  [3:0] bit_cnt_q;
   wire       sclk_s = sync2_q[2];
   wire       ss_n_s = sync2_q[1];
   wire       mosi_s = sync2_q[0];
   wire       rise   = sclk_s & ~sclk_prev_q;
   wire       fall   = ~sclk_s & sclk_prev_q;
   wire       cap_e  = serial_clock_polarity ? fall : rise;
   wire       lau_e  = serial_clock_polarity ? rise : fall;
   wire       sel    = ~ss_n_s;
   wire       rev_on = cc_hs_rev_spi_q;
   // pins are asynchronous, so two flops before any logic looks
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sync1_q <= 3'h2;
         sync2_q <= 3'h2;
      end
      else
      begin
         sync1_q <= {spi_sclk, spi_ss_n, spi_mosi};
         sync2_q <= sync1_q;
      end
   end
   // bused setups need miso released while another slave is selected
   assign spi_miso_oe = rev_on & (~miso_mode | sel);
   // sclk is sampled at sys_clk, which limits spi rate to well below
   // a quarter of sys_clk; that is ample for the control channel
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sclk_prev_q    <= 1'b0;
         ss_n_prev_q    <= 1'b1;
         rx_sh_q        <= 8'h00;
         tx_sh_q        <= 8'h00;
         bit_cnt_q      <= 4'h0;
         spi_miso_o_q   <= 1'b0;
         rev_rx_data_q  <= 8'h00;
         rev_rx_valid_q <= 1'b0;
      end
      else
      begin
         sclk_prev_q    <= sclk_s;
         ss_n_prev_q    <= ss_n_s;
         rev_rx_valid_q <= 1'b0;
         if (~rev_on | ~sel)
            bit_cnt_q <= 4'h0;
         else if (ss_n_prev_q | (bit_cnt_q == `DLAC_SPI_BITS))
         begin
            // new byte: first bit goes out before the first capture
            spi_miso_o_q <= rev_tx_data[7];
            tx_sh_q      <= {rev_tx_data[6:0], 1'b0};
            bit_cnt_q    <= 4'h0;
         end
         else
         begin
            if (cap_e)
            begin
               rx_sh_q   <= {rx_sh_q[6:0], mosi_s};
               bit_cnt_q <= bit_cnt_q + 4'h1;
               if (bit_cnt_q == `DLAC_SPI_BITS - 4'h1)
               begin
                  rev_rx_data_q  <= {rx_sh_q[6:0], mosi_s};
                  rev_rx_valid_q <= 1'b1;
               end
            end
            if (lau_e & (bit_cnt_q != 4'h0))
            begin
               spi_miso_o_q <= tx_sh_q[7];
               tx_sh_q      <= {tx_sh_q[6:0], 1'b0};
            end
         end
      end
   end
endmodule // dlac_regs

// file: rtl/dlac_consts.vh
// dlac_consts.vh: offsets, field positions, reset values and
// encodings for the link, audio clock and equalizer control slice.
// assumes it is included by its bare name in every dlac design file.
`ifndef DLAC_CONSTS_VH
`define DLAC_CONSTS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses on the control register port)
// ----------------------------------------------------------------
`define DLAC_ADDR_AUDIO_DIV   8'h3A
`define DLAC_ADDR_EQUALIZER_SETTING_READBACK   8'h3B
`define DLAC_ADDR_LINK_FAULT  8'h41
`define DLAC_ADDR_CC_SPEED    8'h43
`define DLAC_ADDR_EQ_MANUAL   8'h44

// ----------------------------------------------------------------
// reset values and unmapped read value
// ----------------------------------------------------------------
`define DLAC_RST_AUDIO_DIV    8'h00
`define DLAC_RST_LINK_FAULT   8'h03
`define DLAC_RST_CC_SPEED     8'h00
`define DLAC_RST_EQ_MANUAL    8'h60
`define DLAC_RD_UNMAPPED      8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DLAC_AD_OUT_OVR       7
`define DLAC_AD_OUT_SEL_HI    6
`define DLAC_AD_OUT_SEL_LO    4
`define DLAC_AD_RSVD_RO       3
`define DLAC_AD_IN_OVR        2
`define DLAC_AD_IN_SEL_HI     1
`define DLAC_AD_IN_SEL_LO     0
`define DLAC_LF_CNT_EN        4
`define DLAC_LF_THR_HI        3
`define DLAC_LF_THR_LO        0
`define DLAC_CC_MISO_MODE     4
`define DLAC_CC_CPOL          3
`define DLAC_CC_MODE_HI       2
`define DLAC_CC_MODE_LO       0
`define DLAC_EQ_UPPER_HI      7
`define DLAC_EQ_UPPER_LO      5
`define DLAC_EQ_LOWER_HI      3
`define DLAC_EQ_LOWER_LO      1
`define DLAC_EQ_BYPASS        0

// ----------------------------------------------------------------
// control channel speed modes
// ----------------------------------------------------------------
`define DLAC_CCM_GPIO         3'h0
`define DLAC_CCM_HS_GPIO1     3'h1
`define DLAC_CCM_HS_GPIO2     3'h2
`define DLAC_CCM_HS_GPIO4     3'h3
`define DLAC_CCM_FWD_SPI      3'h4
`define DLAC_CCM_HS_FWD_SPI   3'h5
`define DLAC_CCM_HS_REV_SPI   3'h7

// ----------------------------------------------------------------
// spi shifter
// ----------------------------------------------------------------
`define DLAC_SPI_BITS         4'h8

`endif

// file: rtl/dlac_link_monitor.v
// dlac_link_monitor: link error counting and lock drop decision.
// assumes sys_clk is the pixel clock and that the error strobes are
// one-cycle pulses from recovery logic on that same clock.
`include "dlac_consts.vh"

module dlac_link_monitor
(
   input  wire       sys_clk,
   input  wire       sys_rst,
   input  wire       link_acquired,
   input  wire       err_clk0,
   input  wire       err_clk1,
   input  wire       link_data_channel_err,
   input  wire       count_en,
   input  wire [3:0] threshold,
   output reg        link_lock_q,
   output reg  [3:0] err_count_q,
   output reg        lock_drop_q
);

   // ----------------------------------------------------------------
   // error merge and counting
   // ----------------------------------------------------------------
   // any of the three monitored channels counts as one error per cycle
   wire       err_any   = err_clk0 | err_clk1 | link_data_channel_err;
   wire [3:0] cnt_inc   = (err_count_q == 4'hF) ? 4'hF
                          : err_count_q + 4'h1;
   // threshold of zero is reached by the very first error
   wire       thr_hit   = (cnt_inc >= threshold);
   wire       drop_now  = link_lock_q & err_any &
                          (~count_en | thr_hit);
   reg        lost_q;

   // lock stays lost until the receiver itself falls out of lock, so a
   // noisy link cannot chatter in and out of the locked state
   always @(posedge sys_clk)
   begin
      if (sys_rst | ~link_acquired)
      begin
         lost_q      <= 1'b0;
         link_lock_q <= 1'b0;
         err_count_q <= 4'h0;
         lock_drop_q <= 1'b0;
      end
      else
      begin
         lock_drop_q <= drop_now;
         if (drop_now)
         begin
            lost_q      <= 1'b1;
            link_lock_q <= 1'b0;
         end
         else
         begin
            link_lock_q <= ~lost_q;
         end
         if (count_en & err_any & link_lock_q)
         begin
            err_count_q <= cnt_inc;
         end
      end
   end

endmodule // dlac_link_monitor

// file: test/dlac_regs_properties.sv
// dlac_regs_props: port-level timing and value checks for dlac_regs.
// assumes it is bound to dlac_regs; one clock, synchronous reset.
module dlac_regs_props
(
   input logic       sys_clk,
   input logic       sys_rst,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic       reg_wr,
   input logic       reg_rd,
   input logic [7:0] reg_rdata_q,
   input logic [1:0] pll_state_machine_in_sel,
   input logic [2:0] mclk_div_log2_q,
   input logic [1:0] vco_in_div_log2_q,
   input logic       link_lock,
   input logic       lock_drop,
   input logic [5:0] eq_setting_q,
   input logic       eq_adapt_en_q,
   input logic [2:0] cc_hs_gpio_count_q,
   input logic       spi_ss_n,
   input logic       spi_miso_oe,
   input logic       rev_rx_valid_q
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   logic [2:0] mode_q;
   logic [2:0] mode_dly_q;
   logic       tri_q;
   wire        w3a = reg_wr && reg_addr == 8'h3A;
   wire        w43 = reg_wr && reg_addr == 8'h43;
   wire        w44 = reg_wr && reg_addr == 8'h44;
   function automatic [2:0] dl2(input [2:0] c);
      dl2 = (c >= 3'h6) ? 3'h0 : (c >= 3'h4) ? 3'h1 : 3'h5 - c;
   endfunction
   function automatic [2:0] gc(input [2:0] m);
      gc = (m == 3'h1) ? 3'h1 : (m == 3'h2) ? 3'h2 : (m == 3'h3) ? 3'h4 : 3'h0;
   endfunction
   // shadow of mode and miso fields; the decoded mode flag lags its
   // register by one more cycle, the miso field does not
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         mode_q     <= 3'h0;
         mode_dly_q <= 3'h0;
         tri_q      <= 1'b0;
      end
      else
      begin
         mode_dly_q <= mode_q;
         if (w43)
         begin
            mode_q <= reg_wdata[2:0];
            tri_q  <= reg_wdata[4];
         end
      end
   end
   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   chk_out_div_code: assert property (
      w3a && reg_wdata[7] |=> ##1
      mclk_div_log2_q == dl2($past(reg_wdata[6:4], 2)))
      else $error("output divide not taken from field");
   chk_in_div_auto: assert property (
      w3a && !reg_wdata[2] ##1 !w3a |=>
      vco_in_div_log2_q == $past(pll_state_machine_in_sel))
      else $error("input divide not taken from pll");
   chk_lock_drop: assert property (
      lock_drop |-> !link_lock ##1 !lock_drop)
      else $error("lock drop pulse malformed");
   chk_bypass_bit: assert property (
      w44 |=> ##1 eq_adapt_en_q == !$past(reg_wdata[0], 2))
      else $error("adapt enable disagrees with bypass");
   chk_manual_eq: assert property (
      w44 && reg_wdata[0] |=> ##1 eq_setting_q ==
      {$past(reg_wdata[7:5], 2), $past(reg_wdata[3:1], 2)})
      else $error("manual equalizer setting wrong");
   chk_status_read: assert property (
      reg_rd && !reg_wr && reg_addr == 8'h3B |=>
      reg_rdata_q == {2'b00, $past(eq_setting_q)})
      else $error("status read wrong");
   chk_gpio_count: assert property (
      w43 |=> ##1 cc_hs_gpio_count_q == gc($past(reg_wdata[2:0], 2)))
      else $error("gpio count wrong");
   chk_miso_driven: assert property (
      mode_dly_q == 3'h7 && !tri_q |-> spi_miso_oe)
      else $error("miso not driven");
   chk_miso_tristate: assert property (
      mode_dly_q == 3'h7 && tri_q && spi_ss_n && $past(spi_ss_n, 3)
      |-> !spi_miso_oe)
      else $error("miso driven while deselected");
   cover property (lock_drop);
   cover property (rev_rx_valid_q);
   cover property (w44 && reg_wdata[0]);
endmodule // dlac_regs_props

bind dlac_regs dlac_regs_props i_props (.*);

// file: test/dlac_spi_host.sv
// dlac_spi_host: behavioural spi master for the reverse control channel.
// assumes the bench calls xfer; sclk rests at the polarity level.
module dlac_spi_host
(
   input  logic sys_clk,
   output logic spi_sclk,
   output logic spi_ss_n,
   output logic spi_mosi,
   input  logic spi_miso
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 8; // sclk kept far below sys_clk/4
   initial
   begin
      spi_sclk = 1'b0;
      spi_ss_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // one byte msb first; capture edge leaves the idle level
   task automatic xfer(input logic cpol, input logic [7:0] tx,
                       output logic [7:0] rx);
      spi_sclk <= cpol;
      repeat (HALF) @(posedge sys_clk);
      spi_ss_n <= 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         spi_mosi <= tx[i]; // launch on idle-going edge
         repeat (HALF) @(posedge sys_clk);
         spi_sclk <= ~cpol; // capture edge
         rx[i] = spi_miso;
         repeat (HALF) @(posedge sys_clk);
         spi_sclk <= cpol;
      end
      repeat (HALF) @(posedge sys_clk);
      spi_ss_n <= 1'b1;
      spi_mosi <= ~spi_mosi; // released line must not hold the last bit
   endtask
endmodule // dlac_spi_host

// file: test/dlac_regs_tb.sv
// dlac_regs_tb: directed register, link monitor and reverse spi tests.
// assumes dlac_spi_host as far side and the bound property checker.
module dlac_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic       sys_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [2:0] pll_state_machine_out_sel = 3'h0;
   logic [1:0] pll_state_machine_in_sel = 2'h0;
   logic       link_acquired = 1'b0;
   logic       err_clk0 = 1'b0;
   logic       err_clk1 = 1'b0;
   logic       link_data_channel_err = 1'b0;
   logic [5:0] adapt_eq_value = 6'h00;
   logic [7:0] rev_tx_data = 8'h00;
   logic [7:0] rx_got = 8'h00;
   logic [7:0] m_rx;
   wire  [7:0] reg_rdata_q, rev_rx_data_q;
   wire  [2:0] mclk_div_log2_q, cc_hs_gpio_count_q;
   wire  [1:0] vco_in_div_log2_q;
   wire  [5:0] eq_setting_q;
   wire        reg_rvalid_q, link_lock, lock_drop, eq_adapt_en_q;
   wire        cc_gpio_normal_q, cc_fwd_spi_q, cc_hs_fwd_spi_q;
   wire        cc_hs_rev_spi_q, spi_miso_o_q, spi_miso_oe, rev_rx_valid_q;
   wire        spi_sclk, spi_ss_n, spi_mosi;
   // a released pin shows the inverse, so a late enable gives a wrong bit
   wire        miso_pin = spi_miso_oe ? spi_miso_o_q : ~spi_miso_o_q;
   wire  [7:0] cc_flags = {1'b0, cc_gpio_normal_q, cc_hs_gpio_count_q,
                           cc_fwd_spi_q, cc_hs_fwd_spi_q, cc_hs_rev_spi_q};
   logic [7:0] dl2 [8] = '{8'h05, 8'h04, 8'h03, 8'h02,
                           8'h01, 8'h01, 8'h00, 8'h00};
   logic [7:0] ccx [8] = '{8'h40, 8'h08, 8'h10, 8'h20,
                           8'h04, 8'h02, 8'h00, 8'h01};
   logic [2:0] ers [3] = '{3'b100, 3'b001, 3'b010};
   int         error_cnt = 0;
   int         compares = 0;
   int         cyc = 0;

   dlac_regs i_dut (.*);
   dlac_spi_host i_host (.sys_clk(sys_clk), .spi_sclk(spi_sclk),
      .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(miso_pin));

   always #5 sys_clk = ~sys_clk;
   // keep the last received byte; valid is only one cycle wide
   always @(posedge sys_clk)
      if (rev_rx_valid_q === 1'b1)
         rx_got <= rev_rx_data_q;
   // hang guard, far above the few hundred cycles needed
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end
   // -----------------------------------------------------------
   // bus and check tasks
   // -----------------------------------------------------------
   task automatic cmp(input string nm, input logic [7:0] exp,
                      input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("wrong value %s exp %h got %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      cmp("rvalid", 8'h01, {7'h00, reg_rvalid_q});
      cmp("rdata", exp, reg_rdata_q);
   endtask
   // derived outputs follow the register by one cycle
   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic pulse(input logic [2:0] e);
      @(posedge sys_clk);
      {err_clk0, err_clk1, link_data_channel_err} <= e;
      @(posedge sys_clk);
      {err_clk0, err_clk1, link_data_channel_err} <= 3'b000;
      #1;
   endtask
   task automatic test_done();
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(8'h3A, 8'h00);
      rd(8'h3B, 8'h00);
      rd(8'h41, 8'h03);
      rd(8'h43, 8'h00);
      rd(8'h44, 8'h60);
      rd(8'h50, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         wr(8'h3A, {1'b1, c[2:0], 2'b01, c[1:0]});
         settle();
         cmp("out div", dl2[c], {5'h00, mclk_div_log2_q});
         cmp("in div", {6'h00, c[1:0]}, {6'h00, vco_in_div_log2_q});
      end
      wr(8'h3A, 8'hFF);
      rd(8'h3A, 8'hF7);
      @(posedge sys_clk);
      pll_state_machine_out_sel <= 3'h2;
      pll_state_machine_in_sel  <= 2'h3;
      wr(8'h3A, 8'h00);
      settle();
      cmp("auto out", 8'h03, {5'h00, mclk_div_log2_q});
      cmp("auto in", 8'h03, {6'h00, vco_in_div_log2_q});
      for (int m = 0; m < 8; m++)
      begin
         wr(8'h43, {5'h00, m[2:0]});
         settle();
         cmp("cc mode", ccx[m], cc_flags);
      end
      wr(8'h44, 8'hAD);
      settle();
      cmp("adapt en", 8'h00, {7'h00, eq_adapt_en_q});
      cmp("eq set", 8'h2E, {2'h0, eq_setting_q});
      wr(8'h3B, 8'hFF);
      rd(8'h3B, 8'h2E);
      rd(8'h44, 8'hAD);
      @(posedge sys_clk);
      adapt_eq_value <= 6'h15;
      wr(8'h44, 8'h60);
      settle();
      cmp("adapt en", 8'h01, {7'h00, eq_adapt_en_q});
      rd(8'h3B, 8'h15);
      @(posedge sys_clk);
      link_acquired <= 1'b1;
      settle();
      cmp("lock", 8'h01, {7'h00, link_lock});
      pulse(3'b010);
      cmp("lock", 8'h00, {7'h00, link_lock});
      cmp("drop", 8'h01, {7'h00, lock_drop});
      wr(8'h41, 8'h13);
      link_acquired <= 1'b0;
      @(posedge sys_clk);
      link_acquired <= 1'b1;
      settle();
      for (int k = 0; k < 3; k++)
      begin
         pulse(ers[k]);
         cmp("lock", (k < 2) ? 8'h01 : 8'h00, {7'h00, link_lock});
      end
      cmp("drop", 8'h01, {7'h00, lock_drop});
      @(posedge sys_clk);
      rev_tx_data <= 8'h3C;
      wr(8'h43, 8'h17);
      settle();
      cmp("miso oe", 8'h00, {7'h00, spi_miso_oe});
      i_host.xfer(1'b0, 8'hA5, m_rx);
      cmp("host rx", 8'h3C, m_rx);
      cmp("dev rx", 8'hA5, rx_got);
      rev_tx_data <= 8'hC3;
      wr(8'h43, 8'h1F);
      settle();
      i_host.xfer(1'b1, 8'h5A, m_rx);
      cmp("host rx", 8'hC3, m_rx);
      cmp("dev rx", 8'h5A, rx_got);
      wr(8'h43, 8'h07);
      settle();
      cmp("miso oe", 8'h01, {7'h00, spi_miso_oe});
      test_done();
   end
endmodule // dlac_regs_tb
